// ===== hdl/bsfp_pkg.sv
// Shared constants and types for the bidirectional FIFO port B / flag block
package bsfp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int BSFP_DEPTH_SMALL = 256;
  localparam int BSFP_DEPTH_LARGE = 512;
  localparam int BSFP_DATA_W = 18;
  localparam int BSFP_OFS_W = 9;
  localparam int BSFP_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BSFP_OFS_W-1:0] BSFP_OFS_RESET = 9'h008;

  // ----------------------------------------------------------------
  // Port A resource select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] BSFP_SEL_FIFO = 3'h0;
  localparam logic [2:0] BSFP_SEL_BYPASS = 3'h1;

  // ----------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BSFP_AB_AE_OFS_ADDR = 8'h00;
  localparam logic [7:0] BSFP_AB_AF_OFS_ADDR = 8'h04;
  localparam logic [7:0] BSFP_BA_AE_OFS_ADDR = 8'h08;
  localparam logic [7:0] BSFP_BA_AF_OFS_ADDR = 8'h0C;
  localparam logic [7:0] BSFP_STATUS_ADDR = 8'h10;
  localparam logic [7:0] BSFP_AB_COUNT_ADDR = 8'h14;
  localparam logic [7:0] BSFP_BA_COUNT_ADDR = 8'h18;

  // Status field positions
  localparam int BSFP_ST_AB_FLAGS_LSB = 0;
  localparam int BSFP_ST_BA_FLAGS_LSB = 4;
  localparam int BSFP_ST_BYP_MODE_BIT = 8;
  localparam int BSFP_ST_AB_PEND_BIT = 9;
  localparam int BSFP_ST_BA_PEND_BIT = 10;

  // Four status flags of one direction, all active low
  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic full_flag_n;
  } bsfp_flags_t;

  localparam bsfp_flags_t BSFP_FLAGS_RESET = 4'b0011;

endpackage

// ===== hdl/bsfp_top.sv
// Bidirectional synchronous FIFO core: flags, port B control, bypass path
`timescale 1ns/1ps

// Functional notes
// - Zero words: empty, almost-empty low; others high
// - One to n words: only almost-empty low
// - n+1 to D-(m+1): all four flags high
// - D-m to D-1: only almost-full low
// - Full depth: almost-full and full low
// - Depth 256 or 512 sets full thresholds
// - B write captures data; disabled ignores data
// - Sampled B write-select forces data hi-Z
// - B read loads output register; enable drives
// - B disabled read holds register and pointer
// - Select 000/1XX: B read pops A-to-B FIFO
// - Select 001: B read returns bypass word
// - Chip select high ends bypass next A edge
// - Bypass done: indicator high, flags cleared
// - One B cycle grace, then FIFO mode
// - A-to-B almost-empty updated on B edges
// - A-to-B almost-full updated on A edges
// - First word visible one or two B edges
// - Offsets reset to eight words
module bsfp_top
  import bsfp_pkg::*;
#(
  parameter int DEPTH = BSFP_DEPTH_SMALL,
  parameter int WIDTH = BSFP_DATA_W
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PORT_A_CLOCK,
  input wire logic PORT_A_CHIP_SELECT_N,
  input wire logic PORT_A_RW,
  input wire logic PORT_A_ENABLE_N,
  input wire logic PORT_A_OUTPUT_ENABLE_N,
  input wire logic [2:0] PORT_A_RESOURCE_SELECT,
  input wire logic [WIDTH-1:0] PORT_A_DATA_IN,
  output logic [WIDTH-1:0] PORT_A_DATA_OUT,
  output logic PORT_A_DATA_OE,
  input wire logic PORT_B_CLOCK,
  input wire logic PORT_B_RW,
  input wire logic PORT_B_ENABLE_N,
  input wire logic PORT_B_OUTPUT_ENABLE_N,
  input wire logic [WIDTH-1:0] PORT_B_DATA_IN,
  output logic [WIDTH-1:0] PORT_B_DATA_OUT,
  output logic PORT_B_DATA_OE,
  output logic PORT_B_BYPASS_INDICATOR_N,
  output bsfp_flags_t AB_FLAGS,
  output bsfp_flags_t BA_FLAGS
);

  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int SW = 2 * WIDTH + 12;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // ----------------------------------------------------------------
  // Pin synchroniser: every pin passes two flops before use
  // ----------------------------------------------------------------
  logic [SW-1:0] pins;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic clk_a_prev_reg;
  logic clk_b_prev_reg;

  assign pins = {PORT_A_CLOCK, PORT_B_CLOCK, PORT_A_CHIP_SELECT_N, PORT_A_RW,
                 PORT_A_ENABLE_N, PORT_A_OUTPUT_ENABLE_N, PORT_A_RESOURCE_SELECT,
                 PORT_B_RW, PORT_B_ENABLE_N, PORT_B_OUTPUT_ENABLE_N,
                 PORT_A_DATA_IN, PORT_B_DATA_IN};

  // Stage one is read only by stage two
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      clk_a_prev_reg <= 1'b0;
      clk_b_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      clk_a_prev_reg <= sync2_reg[SW-1];
      clk_b_prev_reg <= sync2_reg[SW-2];
    end
  end

  // Unpacked view of the synchronised pins
  logic s_clk_a, s_clk_b, s_cs_n, s_rw_a, s_en_a_n, s_oe_a_n;
  logic s_rw_b, s_en_b_n, s_oe_b_n;
  logic [2:0] s_sel;
  logic [WIDTH-1:0] s_da, s_db;
  assign {s_clk_a, s_clk_b, s_cs_n, s_rw_a, s_en_a_n, s_oe_a_n, s_sel,
          s_rw_b, s_en_b_n, s_oe_b_n, s_da, s_db} = sync2_reg;

  // Port clocks are sampled, so each edge is a one-cycle strobe
  logic a_rise, b_rise;
  assign a_rise = s_clk_a & ~clk_a_prev_reg;
  assign b_rise = s_clk_b & ~clk_b_prev_reg;

  // ----------------------------------------------------------------
  // Storage, pointers and counts
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] ab_mem [DEPTH];
  logic [WIDTH-1:0] ba_mem [DEPTH];
  logic [AW-1:0] ab_wptr_reg, ab_rptr_reg, ba_wptr_reg, ba_rptr_reg;
  logic [CW-1:0] ab_count_reg, ba_count_reg, ab_count_next, ba_count_next;
  logic [BSFP_OFS_W-1:0] ab_ae_ofs_reg, ab_af_ofs_reg, ba_ae_ofs_reg, ba_af_ofs_reg;
  logic byp_mode_reg, b_byp_reg, ab_pend_reg, ba_pend_reg;
  logic [WIDTH-1:0] ab_byp_data_reg, ba_byp_data_reg;
  logic rw_a_reg, rw_b_reg;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  logic a_wr, a_rd, a_fifo, a_byp, b_wr, b_rd;
  logic ab_push, ab_pop, ba_push, ba_pop;
  logic a_byp_wr, a_byp_rd, b_byp_wr, b_byp_rd, b_forced;

  assign a_wr = a_rise & ~s_cs_n & ~s_rw_a & ~s_en_a_n;
  assign a_rd = a_rise & ~s_cs_n & s_rw_a & ~s_en_a_n;
  assign a_fifo = (s_sel == BSFP_SEL_FIFO);
  assign a_byp = (s_sel == BSFP_SEL_BYPASS);
  assign b_wr = b_rise & ~s_rw_b & ~s_en_b_n;
  assign b_rd = b_rise & s_rw_b & ~s_en_b_n;

  // Full and empty guard the arrays against over- and underrun
  assign ab_push = a_wr & a_fifo & (ab_count_reg != DEPTH_C);
  assign ba_pop = a_rd & a_fifo & (ba_count_reg != '0);
  assign ab_pop = b_rd & ~b_byp_reg & (ab_count_reg != '0);
  assign ba_push = b_wr & ~b_byp_reg & (ba_count_reg != DEPTH_C);
  assign a_byp_wr = a_wr & a_byp;
  assign a_byp_rd = a_rd & a_byp;
  assign b_byp_rd = b_rd & b_byp_reg;
  assign b_byp_wr = b_wr & b_byp_reg;
  // Grace edge: A has left bypass, B gets this one edge only
  assign b_forced = b_rise & b_byp_reg & ~byp_mode_reg;

  // Word counts follow accepted transfers only
  always_comb
  begin
    ab_count_next = ab_count_reg + CW'(ab_push) - CW'(ab_pop);
    ba_count_next = ba_count_reg + CW'(ba_push) - CW'(ba_pop);
  end

  // Pointers and counts
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ab_wptr_reg <= '0;
      ab_rptr_reg <= '0;
      ba_wptr_reg <= '0;
      ba_rptr_reg <= '0;
      ab_count_reg <= '0;
      ba_count_reg <= '0;
    end
    else
    begin
      ab_wptr_reg <= ab_wptr_reg + AW'(ab_push);
      ab_rptr_reg <= ab_rptr_reg + AW'(ab_pop);
      ba_wptr_reg <= ba_wptr_reg + AW'(ba_push);
      ba_rptr_reg <= ba_rptr_reg + AW'(ba_pop);
      ab_count_reg <= ab_count_next;
      ba_count_reg <= ba_count_next;
    end
  end

  // Array writes, no reset needed on storage
  always_ff @(posedge REF_CLK)
  begin
    if (ab_push)
      ab_mem[ab_wptr_reg] <= s_da;
    if (ba_push)
      ba_mem[ba_wptr_reg] <= s_db;
  end

  // ----------------------------------------------------------------
  // Bypass control
  // ----------------------------------------------------------------
  // Mode follows port A select; chip select high drops it next A edge
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      byp_mode_reg <= 1'b0;
    else if (a_rise)
      byp_mode_reg <= ~s_cs_n & a_byp;
  end

  // Port B view of bypass lags by one B edge, giving the grace cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      b_byp_reg <= 1'b0;
    else if (b_rise)
      b_byp_reg <= byp_mode_reg;
  end

  // Pending bypass words; a new word wins over a clear in one cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ab_pend_reg <= 1'b0;
      ba_pend_reg <= 1'b0;
      ab_byp_data_reg <= '0;
      ba_byp_data_reg <= '0;
    end
    else
    begin
      if (a_byp_wr)
        ab_byp_data_reg <= s_da;
      if (b_byp_wr)
        ba_byp_data_reg <= s_db;
      if (a_byp_wr)
        ab_pend_reg <= 1'b1;
      else if (b_byp_rd || b_forced)
        ab_pend_reg <= 1'b0;
      if (b_byp_wr)
        ba_pend_reg <= 1'b1;
      else if (a_byp_rd || b_forced)
        ba_pend_reg <= 1'b0;
    end
  end

  // Indicator rises once B has taken or lost the last bypass word
  assign PORT_B_BYPASS_INDICATOR_N = ~ab_pend_reg;

  // ----------------------------------------------------------------
  // Output registers and drive enables
  // ----------------------------------------------------------------
  // Port B output register: FIFO word or bypass word, else holds
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      PORT_B_DATA_OUT <= '0;
    else if (ab_pop)
      PORT_B_DATA_OUT <= ab_mem[ab_rptr_reg];
    else if (b_byp_rd)
      PORT_B_DATA_OUT <= ab_byp_data_reg;
  end

  // Port A output register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      PORT_A_DATA_OUT <= '0;
    else if (ba_pop)
      PORT_A_DATA_OUT <= ba_mem[ba_rptr_reg];
    else if (a_byp_rd)
      PORT_A_DATA_OUT <= ba_byp_data_reg;
  end

  // Direction as last qualified by each port clock
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rw_a_reg <= 1'b0;
      rw_b_reg <= 1'b0;
    end
    else
    begin
      if (a_rise)
        rw_a_reg <= s_rw_a;
      if (b_rise)
        rw_b_reg <= s_rw_b;
    end
  end

  // A sampled write select releases the bus even with enable low
  assign PORT_B_DATA_OE = rw_b_reg & ~s_oe_b_n;
  assign PORT_A_DATA_OE = rw_a_reg & ~s_cs_n & ~s_oe_a_n;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Five-level decode of the next count against the two offsets
  function automatic bsfp_flags_t flags_of(input logic [CW-1:0] cnt,
                                           input logic [BSFP_OFS_W-1:0] n_ofs,
                                           input logic [BSFP_OFS_W-1:0] m_ofs);
    logic [CW+BSFP_OFS_W-1:0] c_w, n_w, m_w, d_w;
    begin
      c_w = (CW+BSFP_OFS_W)'(cnt);
      n_w = (CW+BSFP_OFS_W)'(n_ofs);
      m_w = (CW+BSFP_OFS_W)'(m_ofs);
      d_w = (CW+BSFP_OFS_W)'(DEPTH_C);
      flags_of.empty_flag_n = (c_w != '0);
      flags_of.almost_empty_flag_n = (c_w > n_w);
      flags_of.almost_full_flag_n = (c_w + m_w < d_w);
      flags_of.full_flag_n = (c_w != d_w);
    end
  endfunction

  bsfp_flags_t ab_dec, ba_dec;
  assign ab_dec = flags_of(ab_count_next, ab_ae_ofs_reg, ab_af_ofs_reg);
  assign ba_dec = flags_of(ba_count_next, ba_ae_ofs_reg, ba_af_ofs_reg);

  // Empty side follows the reader's clock, full side the writer's;
  // a write seen late by the reader slips to its next edge
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      AB_FLAGS <= BSFP_FLAGS_RESET;
      BA_FLAGS <= BSFP_FLAGS_RESET;
    end
    else
    begin
      if (b_rise)
      begin
        AB_FLAGS.empty_flag_n <= ab_dec.empty_flag_n;
        AB_FLAGS.almost_empty_flag_n <= ab_dec.almost_empty_flag_n;
        BA_FLAGS.almost_full_flag_n <= ba_dec.almost_full_flag_n;
        BA_FLAGS.full_flag_n <= ba_dec.full_flag_n;
      end
      if (a_rise)
      begin
        AB_FLAGS.almost_full_flag_n <= ab_dec.almost_full_flag_n;
        AB_FLAGS.full_flag_n <= ab_dec.full_flag_n;
        BA_FLAGS.empty_flag_n <= ba_dec.empty_flag_n;
        BA_FLAGS.almost_empty_flag_n <= ba_dec.almost_empty_flag_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, read data captured in setup
  // ----------------------------------------------------------------
  logic apb_wr, apb_setup, addr_ok;
  logic [31:0] rd_mux;
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr = PSEL & PENABLE & PWRITE & addr_ok;

  // Read decode; unmapped offsets answer zero with an error
  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = '0;
    unique case (PADDR)
      BSFP_AB_AE_OFS_ADDR: rd_mux = 32'(ab_ae_ofs_reg);
      BSFP_AB_AF_OFS_ADDR: rd_mux = 32'(ab_af_ofs_reg);
      BSFP_BA_AE_OFS_ADDR: rd_mux = 32'(ba_ae_ofs_reg);
      BSFP_BA_AF_OFS_ADDR: rd_mux = 32'(ba_af_ofs_reg);
      BSFP_STATUS_ADDR:
      begin
        rd_mux[BSFP_ST_AB_FLAGS_LSB +: 4] = AB_FLAGS;
        rd_mux[BSFP_ST_BA_FLAGS_LSB +: 4] = BA_FLAGS;
        rd_mux[BSFP_ST_BYP_MODE_BIT] = byp_mode_reg;
        rd_mux[BSFP_ST_AB_PEND_BIT] = ab_pend_reg;
        rd_mux[BSFP_ST_BA_PEND_BIT] = ba_pend_reg;
      end
      BSFP_AB_COUNT_ADDR: rd_mux = 32'(ab_count_reg);
      BSFP_BA_COUNT_ADDR: rd_mux = 32'(ba_count_reg);
      default: addr_ok = 1'b0;
    endcase
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  // Registered read data, stable through the access phase
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      PRDATA <= '0;
    else if (apb_setup)
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
  end

  // Offset registers steer the flag thresholds
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ab_ae_ofs_reg <= BSFP_OFS_RESET;
      ab_af_ofs_reg <= BSFP_OFS_RESET;
      ba_ae_ofs_reg <= BSFP_OFS_RESET;
      ba_af_ofs_reg <= BSFP_OFS_RESET;
    end
    else if (apb_wr)
    begin
      if (PADDR == BSFP_AB_AE_OFS_ADDR)
        ab_ae_ofs_reg <= PWDATA[BSFP_OFS_W-1:0];
      if (PADDR == BSFP_AB_AF_OFS_ADDR)
        ab_af_ofs_reg <= PWDATA[BSFP_OFS_W-1:0];
      if (PADDR == BSFP_BA_AE_OFS_ADDR)
        ba_ae_ofs_reg <= PWDATA[BSFP_OFS_W-1:0];
      if (PADDR == BSFP_BA_AF_OFS_ADDR)
        ba_af_ofs_reg <= PWDATA[BSFP_OFS_W-1:0];
    end
  end

endmodule

// ===== test/bsfp_port_model.sv
// Far-side logic on ports A and B: port clocks and one-edge pin cycles
`timescale 1ns/1ps
module bsfp_port_model
  import bsfp_pkg::*;
(
  input wire logic ref_clk,
  output logic a_clk,
  output logic b_clk,
  output logic a_cs_n,
  output logic a_rw,
  output logic a_en_n,
  output logic [2:0] a_sel,
  output logic [BSFP_DATA_W-1:0] a_data,
  output logic b_rw,
  output logic b_en_n,
  output logic b_oe_n,
  output logic [BSFP_DATA_W-1:0] b_data
);
  logic [3:0] a_div, b_div;

  // Quiet pins at time zero
  initial
  begin
    {a_clk, b_clk, a_rw, b_rw, a_div, b_div} = 12'h000;
    {a_cs_n, a_en_n, b_en_n, b_oe_n} = 4'hf;
    a_sel = BSFP_SEL_FIFO;
    a_data = 18'h0_0000;
    b_data = 18'h0_0000;
  end

  // A every 8 and B every 10 system cycles, so the two edges drift apart
  always @(posedge ref_clk)
  begin
    a_div <= (a_div == 4'h3) ? 4'h0 : a_div + 4'h1;
    b_div <= (b_div == 4'h4) ? 4'h0 : b_div + 4'h1;
    if (a_div == 4'h3)
      a_clk <= ~a_clk;
    if (b_div == 4'h4)
      b_clk <= ~b_clk;
  end

  // One port A cycle around one clock rise; released data shows inverted
  task automatic a_op(input logic cs_n, input logic rw, input logic [2:0] sel,
                      input logic [BSFP_DATA_W-1:0] d);
    @(negedge a_clk);
    @(posedge ref_clk);
    {a_cs_n, a_rw, a_en_n, a_sel, a_data} <= {cs_n, rw, 1'b0, sel, d};
    @(posedge a_clk);
    repeat (4) @(posedge ref_clk);
    a_en_n <= 1'b1;
    a_data <= ~d;
    repeat (24) @(posedge ref_clk);
  endtask

  // One port B cycle; a write first lets one idle edge pass undriven
  task automatic b_op(input logic rw, input logic oe_n, input logic en_n,
                      input logic [BSFP_DATA_W-1:0] d);
    @(negedge b_clk);
    @(posedge ref_clk);
    if (!rw)
    begin
      // Idle edge samples write select low, so the core lets go first
      {b_rw, b_oe_n} <= 2'b01;
      @(negedge b_clk);
      @(posedge ref_clk);
    end
    {b_rw, b_oe_n, b_en_n, b_data} <= {rw, oe_n, en_n, d};
    @(posedge b_clk);
    repeat (4) @(posedge ref_clk);
    b_en_n <= 1'b1;
    b_data <= ~d;
    repeat (24) @(posedge ref_clk);
  endtask
endmodule

// ===== test/bsfp_top_bench.sv
// Self-checking bench: registers, FIFO flags, port B control and bypass
`timescale 1ns/1ps
module bsfp_top_bench
  import bsfp_pkg::*;
;
  localparam int D = BSFP_DEPTH_SMALL;
  localparam int N = 3;
  localparam int M = 5;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, serr, a_clk, b_clk, a_cs_n, a_rw, a_en_n, b_rw, b_en_n;
  logic b_oe_n, b_oe, byp_n;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0] a_sel;
  logic [BSFP_DATA_W-1:0] a_d, a_out, b_d, b_out;
  bsfp_flags_t ab_f, ba_f;
  int n_errors = 0, tests_run = 0;

  bsfp_port_model pm (.ref_clk(ref_clk), .a_clk(a_clk), .b_clk(b_clk), .a_cs_n(a_cs_n),
    .a_rw(a_rw), .a_en_n(a_en_n), .a_sel(a_sel), .a_data(a_d), .b_rw(b_rw),
    .b_en_n(b_en_n), .b_oe_n(b_oe_n), .b_data(b_d));

  // Port B wire: the core wins while it drives, else the far side
  bsfp_top #(.DEPTH(D)) dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PORT_A_CLOCK(a_clk), .PORT_A_CHIP_SELECT_N(a_cs_n),
    .PORT_A_RW(a_rw), .PORT_A_ENABLE_N(a_en_n), .PORT_A_OUTPUT_ENABLE_N(1'b1),
    .PORT_A_RESOURCE_SELECT(a_sel), .PORT_A_DATA_IN(a_d), .PORT_A_DATA_OUT(a_out),
    .PORT_A_DATA_OE(), .PORT_B_CLOCK(b_clk), .PORT_B_RW(b_rw), .PORT_B_ENABLE_N(b_en_n),
    .PORT_B_OUTPUT_ENABLE_N(b_oe_n), .PORT_B_DATA_IN(b_oe ? b_out : b_d),
    .PORT_B_DATA_OUT(b_out), .PORT_B_DATA_OE(b_oe), .PORT_B_BYPASS_INDICATOR_N(byp_n),
    .AB_FLAGS(ab_f), .BA_FLAGS(ba_f));

  // 20 MHz clock, reset held for eight cycles
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
  end

  // ------------------------------------------------------------
  // Bus cycle, comparison and expected flags
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 50)
      n_errors++;
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Flag pattern from the stored count and both offsets
  function automatic bsfp_flags_t fx(input int c, input int n, input int m);
    return {c != 0, c > n, c + m < D, c != D};
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well past the roughly 19k cycles the tests take
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    int k;
    @(negedge rst);
    chk(32'(ab_f), 32'(fx(0, 8, 8)));
    chk(32'(ba_f), 32'(fx(0, 8, 8)));
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0000_0000);
      chk(rd, 32'h0000_0008);
    end
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(serr), 32'h0000_0001);
    apb(1'b1, BSFP_AB_AE_OFS_ADDR, 32'(N));
    apb(1'b1, BSFP_AB_AF_OFS_ADDR, 32'(M));
    $display("reset and offsets done");
    // Fill one past full: every count band of the flags is passed
    for (k = 1; k <= D + 1; k++)
    begin
      pm.a_op(1'b0, 1'b0, BSFP_SEL_FIFO, 18'(k));
      chk(32'(ab_f), 32'(fx((k > D) ? D : k, N, M)));
    end
    apb(1'b0, BSFP_AB_COUNT_ADDR, 32'h0000_0000);
    chk(rd, 32'(D));
    $display("fill done");
    // Drain with port A deselected on an offset code
    pm.a_op(1'b1, 1'b1, 3'h4, 18'h0_0000);
    for (k = 1; k <= D; k++)
    begin
      pm.b_op(1'b1, 1'b0, 1'b0, 18'h0_0000);
      chk(32'(b_out), 32'(k));
      chk(32'(ab_f), 32'(fx(D - k, N, M)));
      if (k == 1)
      begin
        pm.b_op(1'b1, 1'b1, 1'b1, 18'h0_0000);
        chk(32'(b_out), 32'h0000_0001);
        chk(32'(b_oe), 32'h0000_0000);
      end
      if (k == 2)
        chk(32'(b_oe), 32'h0000_0001);
    end
    pm.b_op(1'b1, 1'b0, 1'b0, 18'h0_0000);
    chk(32'(b_out), 32'(D));
    $display("drain done");
    // Port B writes, one with enable off
    pm.b_op(1'b0, 1'b0, 1'b0, 18'h2_abcd);
    chk(32'(b_oe), 32'h0000_0000);
    pm.b_op(1'b0, 1'b1, 1'b1, 18'h1_1111);
    apb(1'b0, BSFP_BA_COUNT_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(32'(ba_f), 32'(fx(1, 8, 8)));
    pm.a_op(1'b0, 1'b1, BSFP_SEL_FIFO, 18'h0_0000);
    chk(32'(a_out), 32'h0002_abcd);
    $display("port B write done");
    // Bypass word, read by port B, then chip select ends the mode
    pm.a_op(1'b0, 1'b0, BSFP_SEL_BYPASS, 18'h1_5a5a);
    chk(32'(byp_n), 32'h0000_0000);
    pm.b_op(1'b1, 1'b0, 1'b0, 18'h0_0000);
    chk(32'(b_out), 32'h0001_5a5a);
    // Second word left unread: leaving bypass must drop it
    pm.a_op(1'b0, 1'b0, BSFP_SEL_BYPASS, 18'h0_3c3c);
    chk(32'(byp_n), 32'h0000_0000);
    pm.a_op(1'b1, 1'b0, BSFP_SEL_BYPASS, 18'h0_0000);
    apb(1'b0, BSFP_STATUS_ADDR, 32'h0000_0000);
    chk(32'(rd[BSFP_ST_BYP_MODE_BIT]), 32'h0000_0000);
    chk(32'(byp_n), 32'h0000_0001);
    pm.b_op(1'b1, 1'b0, 1'b0, 18'h0_0000);
    chk(32'(b_out), 32'h0001_5a5a);
    $display("bypass done");
    tally_and_finish;
  end
endmodule

// ===== test/bsfp_top_sva.sv
// Checker on the FIFO core ports: A-to-B flag domains, port B output, bypass
`timescale 1ns/1ps
module bsfp_top_sva
  import bsfp_pkg::*;
#(
  parameter int WIDTH = BSFP_DATA_W
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PORT_A_CLOCK,
  input wire logic PORT_A_CHIP_SELECT_N,
  input wire logic [2:0] PORT_A_RESOURCE_SELECT,
  input wire logic PORT_B_CLOCK,
  input wire logic PORT_B_RW,
  input wire logic PORT_B_ENABLE_N,
  input wire logic PORT_B_OUTPUT_ENABLE_N,
  input wire logic [WIDTH-1:0] PORT_B_DATA_OUT,
  input wire logic PORT_B_DATA_OE,
  input wire logic PORT_B_BYPASS_INDICATOR_N,
  input wire bsfp_flags_t AB_FLAGS,
  input wire bsfp_flags_t BA_FLAGS
);
  // ------------------------------------------------------------
  // Ages since clock rises and requests, saturating
  // ------------------------------------------------------------
  logic a_q, b_q;
  logic [7:0] a_age, b_age, rd_age, byp_age;

  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // Sampled pin rises; the core adds a few synchroniser cycles after them
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      {a_q, b_q} <= 2'h0;
      {a_age, b_age, rd_age, byp_age} <= 32'hffff_ffff;
    end
    else
    begin
      a_q <= PORT_A_CLOCK;
      b_q <= PORT_B_CLOCK;
      a_age <= (PORT_A_CLOCK && !a_q) ? 8'h00 : sat(a_age);
      b_age <= (PORT_B_CLOCK && !b_q) ? 8'h00 : sat(b_age);
      rd_age <= (PORT_B_RW && !PORT_B_ENABLE_N) ? 8'h00 : sat(rd_age);
      byp_age <= (!PORT_A_CHIP_SELECT_N && PORT_A_RESOURCE_SELECT == BSFP_SEL_BYPASS) ?
        8'h00 : sat(byp_age);
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  rst_flags_a: assert property ($fell(RST) |-> AB_FLAGS == BSFP_FLAGS_RESET
    && BA_FLAGS == BSFP_FLAGS_RESET) else $error("flags not at reset pattern");
  ab_flag_order_a: assert property ((AB_FLAGS.empty_flag_n || !AB_FLAGS.almost_empty_flag_n)
    && (AB_FLAGS.full_flag_n || !AB_FLAGS.almost_full_flag_n)) else $error("ab flags clash");
  ba_flag_order_a: assert property ((BA_FLAGS.empty_flag_n || !BA_FLAGS.almost_empty_flag_n)
    && (BA_FLAGS.full_flag_n || !BA_FLAGS.almost_full_flag_n)) else $error("ba flags clash");
  ab_empty_side_a: assert property ($changed(AB_FLAGS[3:2]) |-> b_age <= 8'd6)
    else $error("ab empty side moved off a port B edge");
  ab_full_side_a: assert property ($changed(AB_FLAGS[1:0]) |-> a_age <= 8'd6)
    else $error("ab full side moved off a port A edge");
  b_out_hold_a: assert property ($changed(PORT_B_DATA_OUT) |-> rd_age <= 8'd6)
    else $error("port B output changed without a read");
  b_drive_cause_a: assert property (PORT_B_DATA_OE |-> !$past(PORT_B_OUTPUT_ENABLE_N, 2))
    else $error("port B drives while disabled");
  bypass_start_a: assert property ($fell(PORT_B_BYPASS_INDICATOR_N) |-> byp_age <= 8'd6)
    else $error("bypass indicator fell without a bypass write");

  // Main scenarios reached
  cover property ($fell(PORT_B_BYPASS_INDICATOR_N));
  cover property (!AB_FLAGS.full_flag_n);
  cover property ($rose(PORT_B_DATA_OE));
endmodule

bind bsfp_top bsfp_top_sva #(.WIDTH(WIDTH)) u_sva (.REF_CLK(REF_CLK), .RST(RST),
  .PORT_A_CLOCK(PORT_A_CLOCK), .PORT_A_CHIP_SELECT_N(PORT_A_CHIP_SELECT_N),
  .PORT_A_RESOURCE_SELECT(PORT_A_RESOURCE_SELECT), .PORT_B_CLOCK(PORT_B_CLOCK),
  .PORT_B_RW(PORT_B_RW), .PORT_B_ENABLE_N(PORT_B_ENABLE_N),
  .PORT_B_OUTPUT_ENABLE_N(PORT_B_OUTPUT_ENABLE_N), .PORT_B_DATA_OUT(PORT_B_DATA_OUT),
  .PORT_B_DATA_OE(PORT_B_DATA_OE), .PORT_B_BYPASS_INDICATOR_N(PORT_B_BYPASS_INDICATOR_N),
  .AB_FLAGS(AB_FLAGS), .BA_FLAGS(BA_FLAGS));
